// *** otp_program_verify_sequencer.sv ***
// configuration memory shadow registers, burn and reload sequencer
//
// Summary of operation
// R1 - programmer signs bytes 0x02 to 0x1D in ascending order
// R2 - signature: 8-bit misr from zero, shift, fold byte, xor 29 on msb
// R3 - programmer stores signature at 0x1E before burning
// R4 - programming only in communication mode, entered when lock bit clear
// R5 - writing 0x20 to 0x23 resets the signal processor
// R6 - programmer reads measured angle at start and stop positions
// R7 - programmer writes 0x0A..0x1E, reads back, proceeds on match
// R8 - programmer rewrites with lock set, reads 0x00..0x1D, signs them
// R9 - final image holds settings, lock and signature, checked before burn
// R10 - burn starts only after 0x70 to 0x62 then 0x51 to 0x63
// R11 - burn completes within 10ms; programmer keeps off meanwhile (bench writes 0x1E during the burn)
// R12 - guard-band check: clear 0x1E, write 0x40 to 0x23
// R13 - threshold write reloads shadow from fuses within 5ms
// R14 - reload good only when 0x1E equals computed signature; code compares only when lock bit set
// R15 - repeat check at normal threshold with zero in 0x23
// R16 - failed post-burn compare marks part bad, never reprogrammed
// R17 - locked part starts in functional mode after reset
// R18 - signature mismatch raises fault, held until reset; code checks only when lock bit set
// R19 - programmer aborts before key writes on any mismatch
`timescale 1ns/1ps
`default_nettype none
module otp_program_verify_sequencer #(
  parameter int           BURN_CYCLES = otp_seq_pkg::BURN_CYCLES, // burn
  parameter logic [247:0] FUSE_INIT   = '0  // fuse contents at power on
) (
  input  wire logic        sys_clk,               // system clock
  input  wire logic        reset_n,               // async reset, low
  input  wire logic        reg_wr,                // register write strobe
  input  wire logic        reg_rd,                // register read strobe
  input  wire logic  [7:0] reg_addr,              // register offset
  input  wire logic  [7:0] reg_wdata,             // write data
  input  wire logic [15:0] angle_value,           // measured angle
  output logic       [7:0] reg_rdata,             // read data, registered
  output logic             comm_mode,             // communication mode
  output logic             functional_mode,       // functional mode
  output logic             dsp_reset,             // processor reset pulse
  output logic             guard_threshold,       // guard-band read on
  output logic             burn_busy,             // burn in progress
  output logic             reload_busy,           // reload in progress
  output logic             signature_check_fault  // sticky fault
);
  import otp_seq_pkg::*;

  typedef struct packed {
    seq_mode_t                        mode;   // sequencer mode
    logic [NUM_BYTES-1:0][7:0]        shadow; // shadow registers
    logic [7:0]                       ctrl;   // control / threshold
    logic                             armed;  // first key seen
    logic [4:0]                       idx;    // reload byte index
    logic [CNT_W-1:0]                 cnt;    // burn timer
    logic                             boot;   // first reload pending
    logic                             comm;   // communication mode
    logic                             fault;  // signature fault
    logic                             dspr;   // processor reset pulse
    logic [7:0]                       rdata;  // read data
  } seq_state_t;

  seq_state_t s;
  seq_state_t next_s;
  // fuses keep their contents through reset; only a burn changes them
  logic [NUM_BYTES-1:0][7:0] fuse = FUSE_INIT;
  logic [NUM_BYTES-1:0][7:0] next_fuse;
  logic       accept;
  logic       locked;
  logic       misr_clear;
  logic       misr_step;
  logic [7:0] misr_data;
  logic [7:0] signature;

  // ----------------------------------------------------------------
  // signature engine
  // ----------------------------------------------------------------
  // signs bytes 0x02..0x1d as they are reloaded
  assign misr_clear = (s.mode == ST_LOAD) && (s.idx == 5'h00);
  assign misr_step  = (s.mode == ST_LOAD) &&
                      (s.idx >= MISR_FIRST[4:0]) &&
                      (s.idx <= MISR_LAST[4:0]);        // see R2
  assign misr_data  = fuse[s.idx];

  misr_signature misr_signature_i (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .clear     (misr_clear),
    .step      (misr_step),
    .data_in   (misr_data),
    .signature (signature)
  );

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_mux(input seq_state_t st,
                                          input logic [7:0]  addr,
                                          input logic [15:0] ang);
    logic [7:0] v;
    v = 8'h00;
    if (addr <= IMAGE_LAST) begin
      v = st.shadow[addr[4:0]];
    end else if (addr == CTRL_ADDR) begin
      v = st.ctrl;
    end else if (addr == ANGLE_HI_ADDR) begin
      v = ang[15:8];
    end else if (addr == ANGLE_LO_ADDR) begin
      v = ang[7:0];
    end
    return v;
  endfunction : read_mux

  // link accepted only when idle and in communication mode
  assign accept = (s.mode == ST_IDLE) && s.comm;        // see R4
  assign locked = s.shadow[LOCK_ADDR[4:0]][LOCK_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.dspr = 1'b0;
    next_fuse   = fuse;
    case (s.mode)
      ST_IDLE: begin
        if (reg_rd && accept) begin
          next_s.rdata = read_mux(s, reg_addr, angle_value);
        end
        if (reg_wr && accept) begin
          next_s.armed = 1'b0;
          if (reg_addr <= IMAGE_LAST) begin
            next_s.shadow[reg_addr[4:0]] = reg_wdata;
          end else if (reg_addr == CTRL_ADDR) begin
            next_s.ctrl = reg_wdata;
            if (reg_wdata == DSP_RESET_VAL) begin
              next_s.dspr = 1'b1;                       // see R5
            end else begin
              next_s.mode = ST_LOAD;                    // see R13
              next_s.idx  = 5'h00;
            end
          end else if (reg_addr == KEY1_ADDR) begin
            next_s.armed = (reg_wdata == KEY1_VAL);     // see R10
          end else if (reg_addr == KEY2_ADDR) begin
            if (s.armed && reg_wdata == KEY2_VAL) begin
              next_s.mode = ST_BURN;                    // see R10
              next_s.cnt  = '0;
            end
          end
        end
      end
      ST_LOAD: begin
        // copy fuses to shadow one byte a cycle
        next_s.shadow[s.idx] = fuse[s.idx];             // see R13
        if (s.idx == IMAGE_LAST[4:0]) begin
          next_s.mode = ST_CHECK;
        end else begin
          next_s.idx = s.idx + 5'h01;
        end
      end
      ST_CHECK: begin
        if (locked && signature != s.shadow[SIG_ADDR[4:0]]) begin
          next_s.fault = 1'b1;                          // see R18
        end
        if (s.boot) begin
          next_s.comm = !locked;                        // see R4 R17
          next_s.boot = 1'b0;
        end
        next_s.mode = ST_IDLE;
      end
      ST_BURN: begin
        // fuses only blow, never restore
        if (s.cnt == CNT_W'(BURN_CYCLES - 1)) begin
          next_fuse   = fuse | s.shadow;                // see R11
          next_s.mode = ST_IDLE;
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      default: begin
        next_s.mode = ST_IDLE;
      end
    endcase
  end

  // state register; start-up reload runs from reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{mode: ST_LOAD, shadow: '0, ctrl: CTRL_RESET,
             armed: 1'b0, idx: 5'h00, cnt: '0, boot: 1'b1, comm: 1'b0,
             fault: 1'b0, dspr: 1'b0, rdata: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  // fuse array; no reset, so a burned image survives a restart
  always_ff @(posedge sys_clk) begin
    fuse <= next_fuse;                                  // see R17
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata             = s.rdata;
  assign comm_mode             = s.comm;
  assign functional_mode       = !s.comm && !s.boot;    // see R17
  assign dsp_reset             = s.dspr;
  assign guard_threshold       = s.ctrl[GUARD_BIT];     // see R12
  assign burn_busy             = (s.mode == ST_BURN);
  assign reload_busy           = (s.mode == ST_LOAD) || (s.mode == ST_CHECK);
  assign signature_check_fault = s.fault;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_key_start_burn: assert property ( // see R10
    reg_wr && accept && reg_addr == KEY2_ADDR && reg_wdata == KEY2_VAL &&
    s.armed |=> burn_busy)
    else $error("burn did not start after both keys");
  a_burn_needs_key: assert property ( // see R10
    $rose(burn_busy) |-> $past(s.armed && reg_addr == KEY2_ADDR))
    else $error("burn started without key sequence");
  a_burn_holds: assert property ( // see R11
    $rose(burn_busy) |-> burn_busy [*8])
    else $error("burn ended too early");
  a_burn_bound: assert property ( // see R11
    burn_busy |-> s.cnt <= CNT_W'(BURN_CYCLES - 1))
    else $error("burn exceeded its time");
  a_dsp_reset_pulse: assert property ( // see R5
    reg_wr && accept && reg_addr == CTRL_ADDR && reg_wdata == DSP_RESET_VAL
    |=> dsp_reset ##1 !dsp_reset)
    else $error("processor reset pulse wrong");
  a_guard_reload: assert property ( // see R12 R13
    reg_wr && accept && reg_addr == CTRL_ADDR && reg_wdata == GUARD_VAL
    |=> reload_busy && guard_threshold ##[1:40] s.mode == ST_IDLE)
    else $error("guard-band reload not finished in time");
  a_fault_sticky: assert property ( // see R18
    signature_check_fault |=> signature_check_fault)
    else $error("signature fault cleared without reset");
  a_fault_cause: assert property ( // see R18
    $rose(signature_check_fault) |-> $past(s.mode == ST_CHECK && locked))
    else $error("signature fault without a locked check");
  a_locked_gate: assert property ( // see R4
    !s.comm && reg_wr && s.mode == ST_IDLE |=> $stable(s.shadow))
    else $error("shadow written outside communication mode");

endmodule : otp_program_verify_sequencer
`default_nettype wire

// *** otp_seq_pkg.sv ***
// constants and types shared by the configuration memory sequencer
package otp_seq_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] IMAGE_LAST    = 8'h1e; // last shadow byte
  localparam logic [7:0] SIG_ADDR      = 8'h1e; // signature_byte
  localparam logic [7:0] CTRL_ADDR     = 8'h23; // dsp_reset_and_read_threshold
  localparam logic [7:0] KEY1_ADDR     = 8'h62; // burn_key_first
  localparam logic [7:0] KEY2_ADDR     = 8'h63; // burn_key_second
  localparam logic [7:0] ANGLE_HI_ADDR = 8'h28; // measured_angle_reg high
  localparam logic [7:0] ANGLE_LO_ADDR = 8'h29; // measured_angle_reg low
  localparam logic [7:0] LOCK_ADDR     = 8'h1d; // byte holding lock bit
  localparam int         LOCK_BIT      = 0;     // customer lock position

  // ----------------------------------------------------------------
  // values and signature range
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY1_VAL      = 8'h70; // first burn key
  localparam logic [7:0] KEY2_VAL      = 8'h51; // second burn key
  localparam logic [7:0] DSP_RESET_VAL = 8'h20; // signal processor reset
  localparam logic [7:0] GUARD_VAL     = 8'h40; // guard-band threshold
  localparam logic [7:0] NORMAL_VAL    = 8'h00; // normal threshold
  localparam int         GUARD_BIT     = 6;     // threshold select bit
  localparam logic [7:0] CTRL_RESET    = 8'h00; // control after reset
  localparam logic [7:0] MISR_FIRST    = 8'h02; // first signed byte
  localparam logic [7:0] MISR_LAST     = 8'h1d; // last signed byte
  localparam logic [7:0] MISR_POLY     = 8'h1d; // feedback value 29
  localparam logic [7:0] MISR_RESET    = 8'h00; // signature start
  localparam int         NUM_BYTES     = 31;    // shadow bytes 0x00..0x1e

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;  // 20 mhz
  localparam int BURN_TIME_MS   = 10;  // longest burn time
  localparam int RELOAD_TIME_MS = 5;   // longest reload time
  localparam int BURN_CYCLES    = BURN_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RELOAD_CYCLES  = RELOAD_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W          = 18;  // burn counter width

  // ----------------------------------------------------------------
  // sequencer modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_LOAD  = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_IDLE  = 4'b0100,
    ST_BURN  = 4'b1000
  } seq_mode_t;

endpackage : otp_seq_pkg

// *** misr_signature.sv ***
// serial 8-bit multiple-input signature register
`timescale 1ns/1ps
`default_nettype none
module misr_signature (
  input  wire logic       sys_clk,   // system clock
  input  wire logic       reset_n,   // async reset, active low
  input  wire logic       clear,     // restart signature at zero
  input  wire logic       step,      // fold in data_in
  input  wire logic [7:0] data_in,   // byte to fold in
  output logic      [7:0] signature  // current signature
);
  import otp_seq_pkg::*;

  typedef struct packed {
    logic [7:0] misr;
  } misr_state_t;

  misr_state_t s;
  misr_state_t next_s;

  // ----------------------------------------------------------------
  // next signature
  // ----------------------------------------------------------------
  // shift, fold byte, feed back on old msb
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.misr = MISR_RESET;
    end else if (step) begin
      next_s.misr = {s.misr[6:0], 1'b0} ^ data_in;
      if (s.misr[7]) begin
        next_s.misr = next_s.misr ^ MISR_POLY;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{misr: MISR_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign signature = s.misr;

endmodule : misr_signature
`default_nettype wire

// *** otp_programmer_model.sv ***
// programmer model: register link driver and signature maker
`timescale 1ns/1ps
`default_nettype none
module otp_programmer_model (
  input  wire logic       sys_clk,   // system clock
  input  wire logic [7:0] reg_rdata, // device read data
  output var  logic       reg_wr,    // write strobe
  output var  logic       reg_rd,    // read strobe
  output var  logic [7:0] reg_addr,  // register offset
  output var  logic [7:0] reg_wdata  // write data
);
  import otp_seq_pkg::*;

  // link idle from time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // one write strobe; released lines carry inverted values
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
  endtask : write_reg

  // one read strobe; data taken once the registered answer settles
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask : read_reg

  // signature over the signed bytes in rising address order
  function automatic logic [7:0] sign_image(input logic [7:0] b [0:30]);
    logic [7:0] m;
    m = MISR_RESET;
    for (int i = MISR_FIRST; i <= MISR_LAST; i++) begin
      m = {m[6:0], 1'b0} ^ b[i] ^ (m[7] ? MISR_POLY : 8'h00);
    end
    return m;
  endfunction : sign_image
endmodule : otp_programmer_model
`default_nettype wire

// *** otp_program_verify_sequencer_tb.sv ***
// self-checking bench for the configuration memory sequencer
`timescale 1ns/1ps
`default_nettype none
module otp_program_verify_sequencer_tb;
  import otp_seq_pkg::*;
  localparam int           BURN_SIM = 50; // shortened burn
  localparam logic [247:0] BAD_FUSE = {8'h00, 8'h01, 232'h0}; // bad sig
  logic        sys_clk, reset_n, reg_wr, reg_rd;
  logic  [7:0] reg_addr, reg_wdata, reg_rdata, d, e, sig;
  logic [15:0] angle_value;
  logic        comm_mode, functional_mode, dsp_reset, guard_threshold;
  logic        burn_busy, reload_busy, fault, comm2, fault2;
  logic  [7:0] img [0:30];
  logic        img_ok, part_bad;
  int          n_fail = 0;
  int          checked = 0;
  int          n_dsp = 0;

  otp_program_verify_sequencer #(.BURN_CYCLES(BURN_SIM))
    otp_program_verify_sequencer_i (.sys_clk, .reset_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .angle_value, .reg_rdata, .comm_mode,
    .functional_mode, .dsp_reset, .guard_threshold, .burn_busy,
    .reload_busy, .signature_check_fault(fault));
  otp_program_verify_sequencer #(.BURN_CYCLES(BURN_SIM), .FUSE_INIT(BAD_FUSE))
    otp_program_verify_sequencer_i2 (.sys_clk, .reset_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .angle_value, .reg_rdata(), .comm_mode(comm2),
    .functional_mode(), .dsp_reset(), .guard_threshold(), .burn_busy(),
    .reload_busy(), .signature_check_fault(fault2));
  otp_programmer_model otp_programmer_model_i (.sys_clk, .reg_rdata,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

  // clock and processor reset pulse counter
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) if (dsp_reset === 1'b1) n_dsp++;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    otp_programmer_model_i.write_reg(a, v);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    otp_programmer_model_i.read_reg(a, v);
  endtask : rd
  task automatic wait_idle;
    int k;
    k = 0;
    while ((reload_busy !== 1'b0 || burn_busy !== 1'b0) && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    chk(k < 400, 1'b1);
    @(negedge sys_clk);
  endtask : wait_idle
  task automatic do_reset;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(reload_busy, 1'b1);
    chk(fault2, 1'b0);
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask : do_reset
  task automatic write_img;
    for (int a = 10; a <= 30; a++) wr(8'(a), img[a]);
  endtask : write_img
  task automatic check_img(input int lo, input int hi);
    for (int a = lo; a <= hi; a++) begin
      rd(8'(a), d);
      chk(d, img[a]);
    end
  endtask : check_img

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_startup;
    do_reset();
    wait_idle();
    chk(comm_mode, 1'b1);
    chk(functional_mode, 1'b0);
    chk(comm2, 1'b0);
    chk(fault2, 1'b1);
  endtask : t_startup
  task automatic t_dsp;
    int n0;
    n0 = n_dsp;
    wr(CTRL_ADDR, DSP_RESET_VAL);
    @(negedge sys_clk);
    chk(reload_busy, 1'b0);
    repeat (3) @(negedge sys_clk);
    chk(16'(n_dsp - n0), 16'd1);
    rd(CTRL_ADDR, d);
    chk(d, DSP_RESET_VAL);
  endtask : t_dsp
  task automatic t_angle;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      angle_value <= i ? 16'h5a0f : 16'hc3e1;
      rd(ANGLE_HI_ADDR, d);
      rd(ANGLE_LO_ADDR, e);
      chk({d, e}, i ? 16'h5a0f : 16'hc3e1);
    end
  endtask : t_angle
  task automatic t_image;
    int f0;
    f0 = n_fail;
    for (int a = 0; a < 31; a++) img[a] = a < 10 ? 8'h00 : 8'(a * 37 + 5);
    img[LOCK_ADDR][LOCK_BIT] = 1'b0;
    write_img();
    check_img(10, 30);
    img[LOCK_ADDR][LOCK_BIT] = 1'b1;
    write_img();
    check_img(0, 29);
    sig = otp_programmer_model_i.sign_image(img);
    img[SIG_ADDR] = sig;
    wr(SIG_ADDR, sig);
    check_img(10, 30);
    rd(8'h50, d);
    chk(d, 8'h00);
    img_ok = (n_fail == f0);
  endtask : t_image
  task automatic t_burn;
    int n;
    int f0;
    n = 0;
    if (!img_ok) begin
      chk(burn_busy, 1'b0);
      return;
    end
    wr(KEY1_ADDR, KEY1_VAL);
    rd(KEY1_ADDR, d);
    chk(d, 8'h00);
    wr(SIG_ADDR, sig);
    wr(KEY2_ADDR, KEY2_VAL);
    repeat (4) @(negedge sys_clk);
    chk(burn_busy, 1'b0);
    wr(KEY1_ADDR, KEY1_VAL);
    wr(KEY2_ADDR, KEY2_VAL);
    fork
      for (int k = 0; k < 200; k++) begin
        @(negedge sys_clk);
        if (burn_busy === 1'b1) n++;
      end
      begin
        repeat (5) @(posedge sys_clk);
        wr(SIG_ADDR, 8'h00);
      end
    join
    chk(16'(n), 16'(BURN_SIM));
    rd(SIG_ADDR, d);
    chk(d, sig);
    f0 = n_fail;
    for (int i = 0; i < 2; i++) begin
      wr(SIG_ADDR, 8'h00);
      wr(CTRL_ADDR, i ? NORMAL_VAL : GUARD_VAL);
      @(negedge sys_clk);
      chk(reload_busy, 1'b1);
      chk(guard_threshold, i ? 1'b0 : 1'b1);
      wait_idle();
      check_img(10, 30);
      chk(fault, 1'b0);
    end
    part_bad = (n_fail != f0);
    chk(part_bad, 1'b0);
  endtask : t_burn
  task automatic t_locked;
    chk(fault2, 1'b1);
    do_reset();
    wait_idle();
    chk(comm_mode, 1'b0);
    chk(functional_mode, 1'b1);
    chk(fault, 1'b0);
    chk(fault2, 1'b1);
    rd(SIG_ADDR, d);
    chk(d, 8'h00);
    // a part that failed its post-burn check is never keyed again
    if (part_bad === 1'b0) begin
      wr(KEY1_ADDR, KEY1_VAL);
      wr(KEY2_ADDR, KEY2_VAL);
    end
    repeat (3) @(negedge sys_clk);
    chk(burn_busy, 1'b0);
  endtask : t_locked

  // watchdog and main sequence
  initial begin
    #1_000_000;
    n_fail++;
    complete_run();
  end
  initial begin
    reset_n = 1'b0;
    angle_value = 16'h0000;
    t_startup();
    t_dsp();
    t_angle();
    t_image();
    t_burn();
    t_locked();
    complete_run();
  end
endmodule : otp_program_verify_sequencer_tb
`default_nettype wire
